// ---- inc/lpc_pkg.sv ----
// Constants shared by the linear PCM codec serial port design files.
// Assumes one 100 MHz reference clock samples every pin of the port except the transmit gain pin.
package lpc_pkg;
  localparam int          SAMPLE_BITS  = 16;
  localparam int          FRAME_CLOCKS = 256;
  localparam int          CNT_W        = 8;
  localparam int          SYNC_STAGES  = 2;
  localparam logic [CNT_W-1:0] CNT_LAST  = 8'hFF;
  localparam logic [CNT_W-1:0] SLOT_LAST = 8'h0F;
  localparam logic [CNT_W-1:0] SLOT_PREV = 8'h0E;
  localparam int          REF_CLK_MHZ  = 100;
  localparam int          MCLK_NOM_KHZ = 2048;
  // Pin positions in the synchroniser vector
  localparam int          PIN_TX_MCLK  = 0;
  localparam int          PIN_RX_MCLK  = 1;
  localparam int          PIN_TX_SYNC  = 2;
  localparam int          PIN_RX_SYNC  = 3;
  localparam int          PIN_RX_DATA  = 4;
  localparam int          PIN_TX_DIS   = 5;
  localparam int          PIN_RX_GAIN  = 6;
  localparam int          PIN_COUNT    = 7;
  // Synchronisers reset low, so a sync pin already low at release cannot arm a frame
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 7'h00;
endpackage : lpc_pkg

// ---- hdl/lpc_frame_timer.sv ----
// Frame timer for one direction: finds master clock falling edges,
// detects the sync start and counts master clocks through the frame.
// Assumes master clock and sync arrive already synchronised.
`timescale 1ns/1ps
module lpc_frame_timer
  import lpc_pkg::*;
(
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             mclk_i,
  input  wire logic             sync_n_i,
  output logic                  fall_o,
  output logic                  start_o,
  output logic                  started_o,
  output logic [CNT_W-1:0]      cnt_o
);
  logic             mclk_q;
  logic             armed_q;
  logic             started_q;
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mclk_q <= 1'b0;
    end else if (ce_i) begin
      mclk_q <= mclk_i;
    end
  end

  assign fall_o = mclk_q & ~mclk_i;
  // first falling edge after low sync
  assign start_o = fall_o & ~sync_n_i & armed_q;

  // Sync must be seen high again before the next start may fire
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
    end else if (ce_i) begin
      if (sync_n_i) begin
        armed_q <= 1'b1;
      end else if (start_o) begin
        armed_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q     <= CNT_LAST;
      started_q <= 1'b0;
    end else if (ce_i && fall_o) begin
      if (start_o) begin
        cnt_q     <= '0;
        started_q <= 1'b1;
      end else if (cnt_q != CNT_LAST) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  assign started_o = started_q;
  assign cnt_o     = cnt_q;
endmodule : lpc_frame_timer

// ---- hdl/lpc_serial_port.sv ----
// Serial PCM port of a linear voice codec: 16-bit samples out and in,
// least significant bit first, framed by active-low syncs.
// Assumes all pins are asynchronous to ref_clk_i, which runs far faster
// than the master clocks; the converter side is on ref_clk_i.
`timescale 1ns/1ps
module lpc_serial_port
  import lpc_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  input  wire logic                   tx_master_clock_i,
  input  wire logic                   rx_master_clock_i,
  input  wire logic                   tx_frame_sync_n_i,
  input  wire logic                   rx_frame_sync_n_i,
  input  wire logic                   rx_serial_in_i,
  input  wire logic                   tx_side_disable_i,
  input  wire logic                   rx_gain_select_i,
  input  wire logic                   tx_gain_select_i,
  input  wire logic [SAMPLE_BITS-1:0] tx_sample_i,
  output logic                        tx_serial_out_o,
  output logic                        tx_serial_out_oe_n_o,
  output logic                        tx_sample_taken_o,
  output logic [SAMPLE_BITS-1:0]      rx_sample_o,
  output logic                        rx_sample_valid_o,
  output logic                        rx_gain_high_o,
  output logic                        tx_enabled_o
);
  import lpc_pkg::*;

  logic [PIN_COUNT-1:0]   pins;
  logic [PIN_COUNT-1:0]   meta_q;
  logic [PIN_COUNT-1:0]   sync_q;
  logic                   tx_fall;
  logic                   tx_start;
  logic                   tx_started;
  logic [CNT_W-1:0]       tx_cnt;
  logic                   rx_fall;
  logic                   rx_start;
  logic                   rx_started;
  logic [CNT_W-1:0]       rx_cnt;
  logic                   tx_en;
  logic                   tx_busy_q;
  logic [SAMPLE_BITS-1:0] tx_shift_q;
  logic                   rx_busy_q;
  logic [SAMPLE_BITS-1:0] rx_shift_q;

  // The transmit gain pin has no function on this variant
  assign pins = {rx_gain_select_i, tx_side_disable_i, rx_serial_in_i,
                 rx_frame_sync_n_i, tx_frame_sync_n_i,
                 rx_master_clock_i, tx_master_clock_i};

  // Two-stage synchronisers; data, clock and sync share equal delay
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
      always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          meta_q[gi] <= PIN_RESET[gi];
          sync_q[gi] <= PIN_RESET[gi];
        end else if (ce_i) begin
          meta_q[gi] <= pins[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  lpc_frame_timer u_tx_timer (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .mclk_i    (sync_q[PIN_TX_MCLK]),
    .sync_n_i  (sync_q[PIN_TX_SYNC]),
    .fall_o    (tx_fall),
    .start_o   (tx_start),
    .started_o (tx_started),
    .cnt_o     (tx_cnt)
  );

  lpc_frame_timer u_rx_timer (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .mclk_i    (sync_q[PIN_RX_MCLK]),
    .sync_n_i  (sync_q[PIN_RX_SYNC]),
    .fall_o    (rx_fall),
    .start_o   (rx_start),
    .started_o (rx_started),
    .cnt_o     (rx_cnt)
  );

  // disable pin gates the transmit side
  assign tx_en = ~sync_q[PIN_TX_DIS];

  // first master clock falling edge after low sync loads and shifts LSB first
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_busy_q         <= 1'b0;
      tx_shift_q        <= '0;
      tx_serial_out_o   <= 1'b0;
      tx_sample_taken_o <= 1'b0;
    end else if (ce_i) begin
      tx_sample_taken_o <= 1'b0;
      if (!tx_en) begin
        tx_busy_q <= 1'b0;
      end else if (tx_start) begin
        tx_busy_q         <= 1'b1;
        tx_serial_out_o   <= tx_sample_i[0];
        tx_shift_q        <= {1'b0, tx_sample_i[SAMPLE_BITS-1:1]};
        tx_sample_taken_o <= 1'b1;
      end else if (tx_fall && tx_busy_q) begin
        if (tx_started && tx_cnt < SLOT_LAST) begin
          tx_serial_out_o <= tx_shift_q[0];
          tx_shift_q      <= {1'b0, tx_shift_q[SAMPLE_BITS-1:1]};
        end else begin
          tx_busy_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_serial_out_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      if (!tx_en) begin
        tx_serial_out_oe_n_o <= 1'b1;
      end else if (tx_start) begin
        tx_serial_out_oe_n_o <= 1'b0;
      end else if (tx_fall && tx_busy_q && !(tx_started && tx_cnt < SLOT_LAST)) begin
        tx_serial_out_oe_n_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_busy_q         <= 1'b0;
      rx_shift_q        <= '0;
      rx_sample_o       <= '0;
      rx_sample_valid_o <= 1'b0;
    end else if (ce_i) begin
      rx_sample_valid_o <= 1'b0;
      if (rx_start) begin
        rx_busy_q  <= 1'b1;
        rx_shift_q <= {sync_q[PIN_RX_DATA], {(SAMPLE_BITS-1){1'b0}}};
      // LSB first, shift toward bit 0
      end else if (rx_fall && rx_busy_q && rx_started) begin
        rx_shift_q <= {sync_q[PIN_RX_DATA], rx_shift_q[SAMPLE_BITS-1:1]};
        if (rx_cnt == SLOT_PREV) begin
          rx_busy_q         <= 1'b0;
          rx_sample_o       <= {sync_q[PIN_RX_DATA], rx_shift_q[SAMPLE_BITS-1:1]};
          rx_sample_valid_o <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_gain_high_o <= 1'b0;
      tx_enabled_o   <= 1'b0;
    end else if (ce_i) begin
      rx_gain_high_o <= sync_q[PIN_RX_GAIN];
      tx_enabled_o   <= tx_en;
    end
  end
endmodule : lpc_serial_port

// ---- test/lpc_port_checker.sv ----
// Checker on the serial port pins: pulses, bit timing, level pins.
// Assumes a 100 MHz reference clock and the nominal master clock.
`timescale 1ns/1ps
module lpc_port_checker (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic tx_side_disable_i,
  input wire logic rx_gain_select_i,
  input wire logic tx_serial_out_o,
  input wire logic tx_serial_out_oe_n_o,
  input wire logic tx_sample_taken_o,
  input wire logic rx_sample_valid_o,
  input wire logic rx_gain_high_o,
  input wire logic tx_enabled_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  taken_pulse_a: assert property (tx_sample_taken_o |=> !tx_sample_taken_o)
    else $error("taken pulse too long");
  valid_pulse_a: assert property (rx_sample_valid_o |=> !rx_sample_valid_o)
    else $error("valid pulse too long");
  drive_start_a: assert property ($fell(tx_serial_out_oe_n_o) |-> tx_sample_taken_o)
    else $error("drive without sample taken");
  taken_drive_a: assert property (tx_sample_taken_o |-> !tx_serial_out_oe_n_o)
    else $error("sample taken while floating");
  bit_stand_a: assert property (!tx_serial_out_oe_n_o && $changed(tx_serial_out_o) |=>
    (tx_serial_out_oe_n_o || $stable(tx_serial_out_o)) [*8]) else $error("bit too short");
  dis_float_a: assert property ($rose(tx_side_disable_i) |-> ##[2:3]
    (tx_serial_out_oe_n_o && !tx_enabled_o)) else $error("disable not obeyed");
  en_back_a: assert property ($fell(tx_side_disable_i) |-> ##[2:3] tx_enabled_o)
    else $error("enable not restored");
  gain_high_a: assert property ($rose(rx_gain_select_i) |-> ##[2:3] rx_gain_high_o)
    else $error("gain not raised");
  cover property (tx_sample_taken_o);
  cover property (rx_sample_valid_o);
  cover property ($rose(tx_side_disable_i));
endmodule : lpc_port_checker

bind lpc_serial_port lpc_port_checker u_chk (.*);

// ---- test/lpc_far_end.sv ----
// Far end: one master clock and one sync for both paths, receive data.
// Assumes the bench ties both clock pins and both sync pins to it.
`timescale 1ns/1ps
module lpc_far_end
  import lpc_pkg::*;
(
  input  wire logic [SAMPLE_BITS-1:0] word_i,
  output logic                        mclk_o,
  output logic                        sync_n_o,
  output logic                        sdat_o
);
  logic [SAMPLE_BITS-1:0] word_q;
  int                     slot = 0;
  initial begin
    mclk_o = 1'h0;
    sync_n_o = 1'h1;
    sdat_o = 1'h0;
    #1000;
    forever begin
      #244.141 mclk_o = 1'h1;
      sync_n_o = (slot > 1);
      if (slot == 0) word_q = word_i;
      sdat_o = (slot < SAMPLE_BITS) ? word_q[slot] : ~sdat_o;
      slot = (slot + 1) % FRAME_CLOCKS;
      #244.141 mclk_o = 1'h0;
    end
  end
endmodule : lpc_far_end

// ---- test/lpc_serial_port_test.sv ----
// Bench: far-end model drives shared clock and sync; words go both ways.
// Assumes the checker is bound into the design by its own file.
`timescale 1ns/1ps
module lpc_serial_port_test;
  import lpc_pkg::*;
  logic ref_clk, rst, mclk, sync_n, rx_dat, tx_dis, rx_gain;
  logic tx_out, oe_n, taken, rx_vld, gain_hi, tx_en;
  logic [SAMPLE_BITS-1:0] tx_smp, far_word, rx_smp, tx_bits;
  int err_total = 0, samples_checked = 0, nbits = 0, ntaken = 0;
  lpc_serial_port u_dut (.ref_clk_i(ref_clk), .rst_i(rst), .ce_i(1'h1),
    .tx_master_clock_i(mclk), .rx_master_clock_i(mclk), .tx_frame_sync_n_i(sync_n),
    .rx_frame_sync_n_i(sync_n), .rx_serial_in_i(rx_dat), .tx_side_disable_i(tx_dis),
    .rx_gain_select_i(rx_gain), .tx_gain_select_i(), .tx_sample_i(tx_smp), // left open
    .tx_serial_out_o(tx_out), .tx_serial_out_oe_n_o(oe_n), .tx_sample_taken_o(taken),
    .rx_sample_o(rx_smp), .rx_sample_valid_o(rx_vld), .rx_gain_high_o(gain_hi),
    .tx_enabled_o(tx_en));
  lpc_far_end u_far (.word_i(far_word), .mclk_o(mclk), .sync_n_o(sync_n), .sdat_o(rx_dat));
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge mclk) begin
    if (oe_n === 1'h0) begin
      tx_bits = {tx_out, tx_bits[SAMPLE_BITS-1:1]};
      nbits++;
    end
  end
  // Count sample-taken pulses away from the launching edge
  always @(negedge ref_clk) begin
    if (taken === 1'h1) ntaken++;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) err_total++;
    if (seen !== exp) $display("mismatch at %0t: %h not %h", $time, seen, exp);
  endtask : check
  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 20000 && s !== 1'h1; i++) @(negedge ref_clk);
    if (s !== 1'h1) check(16'(s), 16'h0001);
    if (s !== 1'h1) stop_test();
  endtask : wait_hi
  task automatic do_frame(input logic [15:0] tw, input logic [15:0] rw, input int nb);
    @(negedge ref_clk);
    tx_smp = tw;
    far_word = rw;
    nbits = 0;
    ntaken = 0;
    wait_hi(rx_vld);
    check(rx_smp, rw);
    wait_hi(oe_n);
    check(16'(nbits), 16'(nb));
    check(16'(ntaken), 16'(nb / 16));
    if (nb > 0) check(tx_bits, tw);
  endtask : do_frame
  task automatic t_frames;
    do_frame(16'hA5C3, 16'h3C5A, 16);
    do_frame(16'h8000, 16'h7FFF, 16);
    do_frame(16'h7FFF, 16'h8000, 16);
    $display("frames done");
  endtask : t_frames
  task automatic t_cut;
    @(negedge ref_clk);
    tx_smp = 16'hC001;
    far_word = 16'h0F0F;
    wait_hi(taken);
    repeat (200) @(negedge ref_clk);
    tx_dis = 1'h1;
    repeat (3) @(negedge ref_clk);
    check(16'(oe_n), 16'h0001);
    tx_dis = 1'h0;
    wait_hi(rx_vld);
    check(rx_smp, 16'h0F0F);
    rst = 1'h1;
    @(negedge ref_clk);
    check({13'h0, oe_n, tx_en, taken}, 16'h0004);
    check(rx_smp, 16'h0000);
    repeat (2) @(negedge ref_clk);
    rst = 1'h0;
    do_frame(16'h0001, 16'hFFFE, 16);
    $display("cut done");
  endtask : t_cut
  task automatic t_levels;
    tx_dis = 1'h1;
    rx_gain = 1'h1;
    do_frame(16'h1234, 16'h0001, 0);
    check({14'h0, tx_en, gain_hi}, 16'h0001);
    tx_dis = 1'h0;
    rx_gain = 1'h0;
    repeat (4) @(negedge ref_clk);
    check({14'h0, tx_en, gain_hi}, 16'h0002);
    $display("levels done");
  endtask : t_levels
  initial begin
    rst = 1'h1;
    tx_dis = 1'h0;
    rx_gain = 1'h0;
    tx_smp = '0;
    far_word = '0;
    repeat (3) @(negedge ref_clk);
    rst = 1'h0;
    t_frames();
    t_cut();
    t_levels();
    stop_test();
  end
endmodule : lpc_serial_port_test
